/* File: rtl/rtcpt_top.sv */
/*
 Real-time counter with prescaler, wrap limit, compare match and periodic
 tick timer, behind a byte-wide register port.
 Assumes the four counter clock sources are slow against ref_clk_i and arrive
 unsynchronised; the debug halt input comes from logic on ref_clk_i.
*/
`timescale 1ns/10ps
`default_nettype none
module rtcpt_top (
	input  wire logic       ref_clk_i,
	input  wire logic       nrst_i,
	input  wire logic       internal_32khz_src_clk_i,
	input  wire logic       internal_1khz_src_clk_i,
	input  wire logic       xtal32k_clk_i,
	input  wire logic       pin_clk_i,
	input  wire logic       debug_halt_i,
	input  wire logic [4:0] addr_i,
	input  wire logic [7:0] wr_data_i,
	input  wire logic       wr_en_i,
	input  wire logic       rd_en_i,
	output logic      [7:0] rd_data_o,
	output logic            rtc_irq_o,
	output logic            pit_irq_o
);
	logic [1:0]                rst_sync;
	logic                      rst_n;
	logic [3:0]                src_meta;
	logic [3:0]                src_sync;
	logic [3:0]                src_prev;
	rtcpt_pkg::rtcpt_clock_source_t  clock_source;
	logic                      rtc_tick;
	logic [7:0]                ctrl_reg;
	logic [7:0]                ctrl_eff;
	logic [1:0]                int_en;
	logic                      wrap_flag;
	logic                      match_flag;
	logic                      keep_run;
	logic [15:0]               cnt;
	logic [15:0]               cnt_shadow;
	logic [15:0]               wrap;
	logic [15:0]               wrap_shadow;
	logic [15:0]               cmp;
	logic [15:0]               cmp_shadow;
	logic [7:0]                pit_reg;
	logic [7:0]                pit_eff;
	logic                      pit_ie;
	logic                      pit_flag;
	logic                      pit_keep_run;
	logic [4:0]                busy;
	logic [1:0]                sync_cnt [rtcpt_pkg::SYNC_N];
	logic [4:0]                sync_start;
	logic [4:0]                sync_done;
	logic [14:0]               pcnt;
	logic [14:0]               pit_cnt;
	logic                      rtc_run;
	logic                      pit_run;
	logic                      ptick;
	logic [15:0]               next_cnt;
	logic                      wrap_set;
	logic                      match_set;
	logic [3:0]                pit_period;
	logic                      pit_issue;
	logic [7:0]                next_rd;

	function automatic logic hit(input logic [4:0] a);
		return wr_en_i && (addr_i == a);
	endfunction

	function automatic logic [14:0] low_mask(input logic [3:0] n);
		return 15'((32'h1 << n) - 32'h1);
	endfunction

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	// Each source is synchronised on its own so that switching sources never
	// exposes a metastable stage to the edge detector.
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			src_meta <= 4'h0;
			src_sync <= 4'h0;
			src_prev <= 4'h0;
		end else begin
			src_meta <= {pin_clk_i, xtal32k_clk_i, internal_1khz_src_clk_i, internal_32khz_src_clk_i};
			src_sync <= src_meta;
			src_prev <= src_sync;
		end
	end

	always_comb begin
		case (clock_source)
			rtcpt_pkg::internal_32khz_src: rtc_tick = src_sync[0] & ~src_prev[0];
			rtcpt_pkg::internal_1khz_src:  rtc_tick = src_sync[1] & ~src_prev[1];
			rtcpt_pkg::crystal_32khz_src:  rtc_tick = src_sync[2] & ~src_prev[2];
			rtcpt_pkg::pin_clock_src:      rtc_tick = src_sync[3] & ~src_prev[3];
			default:                       rtc_tick = 1'b0;
		endcase
	end

	always_comb begin
		sync_start = 5'h00;
		sync_start[rtcpt_pkg::SYNC_CTRL] = hit(rtcpt_pkg::ADDR_CTRL);
		sync_start[rtcpt_pkg::SYNC_CNT]  = hit(rtcpt_pkg::ADDR_CNT_L) | hit(rtcpt_pkg::ADDR_CNT_H);
		sync_start[rtcpt_pkg::SYNC_WRAP] = hit(rtcpt_pkg::ADDR_WRAP_L) | hit(rtcpt_pkg::ADDR_WRAP_H);
		sync_start[rtcpt_pkg::SYNC_CMP]  = hit(rtcpt_pkg::ADDR_CMP_L) | hit(rtcpt_pkg::ADDR_CMP_H);
		sync_start[rtcpt_pkg::SYNC_PIT]  = hit(rtcpt_pkg::ADDR_PIT_CTRL);
		for (int i = 0; i < rtcpt_pkg::SYNC_N; i++) begin
			sync_done[i] = busy[i] & rtc_tick & ~sync_start[i]
				& (sync_cnt[i] == rtcpt_pkg::SYNC_TICKS - 2'h1);
		end
	end

	// A write restarts its own crossing, so a second byte written while the
	// first is pending delays both until two ticks after the last one.
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			busy <= 5'h00;
			for (int i = 0; i < rtcpt_pkg::SYNC_N; i++) begin
				sync_cnt[i] <= 2'h0;
			end
		end else begin
			for (int i = 0; i < rtcpt_pkg::SYNC_N; i++) begin
				if (sync_start[i]) begin
					busy[i]     <= 1'b1;
					sync_cnt[i] <= 2'h0;
				end else if (sync_done[i]) begin
					busy[i] <= 1'b0;
				end else if (busy[i] && rtc_tick) begin
					sync_cnt[i] <= sync_cnt[i] + 2'h1;
				end
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg     <= rtcpt_pkg::BYTE_RST;
			ctrl_eff     <= rtcpt_pkg::BYTE_RST;
			int_en       <= 2'h0;
			keep_run     <= 1'b0;
			clock_source       <= rtcpt_pkg::internal_32khz_src;
			pit_reg      <= rtcpt_pkg::BYTE_RST;
			pit_eff      <= rtcpt_pkg::BYTE_RST;
			pit_ie       <= 1'b0;
			pit_keep_run <= 1'b0;
		end else begin
			if (hit(rtcpt_pkg::ADDR_CTRL)) begin
				ctrl_reg <= wr_data_i & rtcpt_pkg::CTRL_MASK;
			end
			if (sync_done[rtcpt_pkg::SYNC_CTRL]) begin
				ctrl_eff <= ctrl_reg;
			end
			if (hit(rtcpt_pkg::ADDR_INT_EN)) begin
				int_en <= wr_data_i[1:0];
			end
			if (hit(rtcpt_pkg::ADDR_DBG)) begin
				keep_run <= wr_data_i[rtcpt_pkg::KEEPRUN_BIT];
			end
			if (hit(rtcpt_pkg::ADDR_CLKSRC)) begin
				clock_source <= rtcpt_pkg::rtcpt_clock_source_t'(wr_data_i[1:0]);
			end
			if (hit(rtcpt_pkg::ADDR_PIT_CTRL)) begin
				pit_reg <= wr_data_i & rtcpt_pkg::PIT_MASK;
			end
			if (sync_done[rtcpt_pkg::SYNC_PIT]) begin
				pit_eff <= pit_reg;
			end
			if (hit(rtcpt_pkg::ADDR_PIT_IE)) begin
				pit_ie <= wr_data_i[0];
			end
			if (hit(rtcpt_pkg::ADDR_PIT_DBG)) begin
				pit_keep_run <= wr_data_i[rtcpt_pkg::KEEPRUN_BIT];
			end
		end
	end

	// Shadows hold what software wrote; the live values change only when the
	// crossing completes.
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			cnt_shadow  <= rtcpt_pkg::CNT_RST;
			wrap_shadow <= rtcpt_pkg::WRAP_RST;
			cmp_shadow  <= rtcpt_pkg::CMP_RST;
			wrap        <= rtcpt_pkg::WRAP_RST;
			cmp         <= rtcpt_pkg::CMP_RST;
		end else begin
			if (hit(rtcpt_pkg::ADDR_CNT_L)) cnt_shadow[7:0] <= wr_data_i;
			if (hit(rtcpt_pkg::ADDR_CNT_H)) cnt_shadow[15:8] <= wr_data_i;
			if (hit(rtcpt_pkg::ADDR_WRAP_L)) wrap_shadow[7:0] <= wr_data_i;
			if (hit(rtcpt_pkg::ADDR_WRAP_H)) wrap_shadow[15:8] <= wr_data_i;
			if (hit(rtcpt_pkg::ADDR_CMP_L)) cmp_shadow[7:0] <= wr_data_i;
			if (hit(rtcpt_pkg::ADDR_CMP_H)) cmp_shadow[15:8] <= wr_data_i;
			if (sync_done[rtcpt_pkg::SYNC_WRAP]) wrap <= wrap_shadow;
			if (sync_done[rtcpt_pkg::SYNC_CMP]) cmp <= cmp_shadow;
		end
	end

	assign rtc_run  = ctrl_eff[rtcpt_pkg::ENABLE_BIT] & ~(debug_halt_i & ~keep_run);
	assign pit_run  = pit_eff[rtcpt_pkg::ENABLE_BIT] & ~(debug_halt_i & ~pit_keep_run);
	assign ptick    = rtc_run & rtc_tick
		& ((pcnt & low_mask(ctrl_eff[rtcpt_pkg::FIELD_MSB:rtcpt_pkg::FIELD_LSB]))
		== low_mask(ctrl_eff[rtcpt_pkg::FIELD_MSB:rtcpt_pkg::FIELD_LSB]));
	assign next_cnt = (cnt == wrap) ? rtcpt_pkg::CNT_RST : cnt + 16'h0001;
	assign wrap_set  = ptick & (cnt == wrap) & ~sync_done[rtcpt_pkg::SYNC_CNT];
	assign match_set = ptick & (next_cnt == cmp) & ~sync_done[rtcpt_pkg::SYNC_CNT];

	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			pcnt <= 15'h0000;
		end else if (!ctrl_eff[rtcpt_pkg::ENABLE_BIT]) begin
			pcnt <= 15'h0000;
		end else if (rtc_run && rtc_tick) begin
			pcnt <= pcnt + 15'h0001;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= rtcpt_pkg::CNT_RST;
		end else if (sync_done[rtcpt_pkg::SYNC_CNT]) begin
			cnt <= cnt_shadow;
		end else if (ptick) begin
			cnt <= next_cnt;
		end
	end

	// Hardware set beats a software clear in the same cycle.
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			wrap_flag  <= 1'b0;
			match_flag <= 1'b0;
			pit_flag   <= 1'b0;
		end else begin
			wrap_flag <= wrap_set | (wrap_flag
				& ~(hit(rtcpt_pkg::ADDR_INT_FLAG) & wr_data_i[rtcpt_pkg::WRAP_BIT]));
			match_flag <= match_set | (match_flag
				& ~(hit(rtcpt_pkg::ADDR_INT_FLAG) & wr_data_i[rtcpt_pkg::MATCH_BIT]));
			pit_flag <= pit_issue | (pit_flag
				& ~(hit(rtcpt_pkg::ADDR_PIT_FLAG) & wr_data_i[0]));
		end
	end

	assign pit_period = pit_eff[rtcpt_pkg::FIELD_MSB:rtcpt_pkg::FIELD_LSB];
	// The reserved interval code behaves like the off code.
	assign pit_issue  = pit_run & rtc_tick
		& (pit_period != rtcpt_pkg::PIT_OFF) & (pit_period != rtcpt_pkg::PIT_RESERVED)
		& ((pit_cnt & low_mask(pit_period + 4'h1)) == low_mask(pit_period + 4'h1));

	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			pit_cnt <= 15'h0000;
		end else if (!pit_eff[rtcpt_pkg::ENABLE_BIT]) begin
			pit_cnt <= 15'h0000;
		end else if (pit_run && rtc_tick) begin
			pit_cnt <= pit_cnt + 15'h0001;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			rtc_irq_o <= 1'b0;
			pit_irq_o <= 1'b0;
		end else begin
			rtc_irq_o <= (wrap_flag & int_en[rtcpt_pkg::WRAP_BIT])
				| (match_flag & int_en[rtcpt_pkg::MATCH_BIT]);
			pit_irq_o <= pit_flag & pit_ie;
		end
	end

	always_comb begin
		case (addr_i)
			rtcpt_pkg::ADDR_CTRL:     next_rd = ctrl_reg;
			rtcpt_pkg::ADDR_STATUS:   next_rd = {4'h0, busy[3:0]};
			rtcpt_pkg::ADDR_INT_EN:   next_rd = {6'h00, int_en};
			rtcpt_pkg::ADDR_INT_FLAG: next_rd = {6'h00, match_flag, wrap_flag};
			rtcpt_pkg::ADDR_DBG:      next_rd = {7'h00, keep_run};
			rtcpt_pkg::ADDR_CLKSRC:   next_rd = {6'h00, clock_source};
			rtcpt_pkg::ADDR_CNT_L:    next_rd = cnt[7:0];
			rtcpt_pkg::ADDR_CNT_H:    next_rd = cnt[15:8];
			rtcpt_pkg::ADDR_WRAP_L:   next_rd = wrap_shadow[7:0];
			rtcpt_pkg::ADDR_WRAP_H:   next_rd = wrap_shadow[15:8];
			rtcpt_pkg::ADDR_CMP_L:    next_rd = cmp_shadow[7:0];
			rtcpt_pkg::ADDR_CMP_H:    next_rd = cmp_shadow[15:8];
			rtcpt_pkg::ADDR_PIT_CTRL: next_rd = pit_reg;
			rtcpt_pkg::ADDR_PIT_STAT: next_rd = {7'h00, busy[rtcpt_pkg::SYNC_PIT]};
			rtcpt_pkg::ADDR_PIT_IE:   next_rd = {7'h00, pit_ie};
			rtcpt_pkg::ADDR_PIT_FLAG: next_rd = {7'h00, pit_flag};
			rtcpt_pkg::ADDR_PIT_DBG:  next_rd = {7'h00, pit_keep_run};
			default:                  next_rd = 8'h00;
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			rd_data_o <= 8'h00;
		end else begin
			rd_data_o <= rd_en_i ? next_rd : 8'h00;
		end
	end

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_n);

	a_halt_freezes: assert property (
		!rtc_run && !sync_done[rtcpt_pkg::SYNC_CNT] |=> $stable(cnt))
		else $error("counter moved while halted");
	a_run_in_debug: assert property (
		debug_halt_i && keep_run && ptick && cnt != wrap && !sync_done[rtcpt_pkg::SYNC_CNT]
		|=> cnt == $past(cnt) + 16'h0001)
		else $error("counter did not advance in debug run");
	a_byte_read: assert property (
		rd_en_i && addr_i == rtcpt_pkg::ADDR_CNT_H |=> rd_data_o == $past(cnt[15:8]))
		else $error("counter high byte read wrong");
	a_sync_apply: assert property (
		$fell(busy[rtcpt_pkg::SYNC_CNT]) |-> cnt == $past(cnt_shadow))
		else $error("counter write not applied at end of sync");
	a_sync_busy: assert property (
		sync_start[rtcpt_pkg::SYNC_WRAP] |=> busy[rtcpt_pkg::SYNC_WRAP] && $stable(wrap))
		else $error("wrap write took effect too early");
	a_wrap_zero: assert property (
		wrap_set |=> cnt == rtcpt_pkg::CNT_RST && wrap_flag)
		else $error("counter did not wrap to zero with flag");
	a_match_flag: assert property (
		match_set |=> match_flag)
		else $error("compare match flag missing");
	// The tick count clears on the edge after the enable drops, not in the same cycle.
	a_pit_off: assert property (
		!pit_eff[rtcpt_pkg::ENABLE_BIT] |-> !pit_issue ##1 pit_cnt == 15'h0000)
		else $error("tick timer active while off");
	a_pit_flag: assert property (
		pit_issue |=> pit_flag [*2])
		else $error("periodic flag not held");
	a_pit_clear: assert property (
		wr_en_i && addr_i == rtcpt_pkg::ADDR_PIT_FLAG && wr_data_i[0] && !pit_issue
		|=> !pit_flag)
		else $error("periodic flag not cleared by one");
	a_pit_gate: assert property (
		!pit_ie |=> !pit_irq_o)
		else $error("periodic request without enable");
	a_pit_stat: assert property (
		sync_start[rtcpt_pkg::SYNC_PIT] ##[1:2] rd_en_i && addr_i == rtcpt_pkg::ADDR_PIT_STAT
		|=> rd_data_o == 8'h01)
		else $error("tick setup pending not shown");
	a_wrap_reset: assert property (
		$rose(rst_n) |-> wrap == rtcpt_pkg::WRAP_RST)
		else $error("wrap limit reset wrong");

	c_wrap:  cover property (wrap_set);
	c_match: cover property (match_set);
	c_pit:   cover property (pit_issue ##[1:100] pit_issue);
	c_sync:  cover property ($fell(busy[rtcpt_pkg::SYNC_CNT]));
endmodule
`default_nettype wire

/* File: rtl/rtcpt_pkg.sv */
/*
 Constants for the real-time counter and periodic tick timer: byte offsets,
 field positions, reset values and the clock source encoding.
 Assumes a byte-wide register port with a five-bit address.
*/
`default_nettype none
package rtcpt_pkg;
	localparam logic [4:0] ADDR_CTRL     = 5'h00;
	localparam logic [4:0] ADDR_STATUS   = 5'h01;
	localparam logic [4:0] ADDR_INT_EN   = 5'h02;
	localparam logic [4:0] ADDR_INT_FLAG = 5'h03;
	localparam logic [4:0] ADDR_DBG      = 5'h05;
	localparam logic [4:0] ADDR_CLKSRC   = 5'h07;
	localparam logic [4:0] ADDR_CNT_L    = 5'h08;
	localparam logic [4:0] ADDR_CNT_H    = 5'h09;
	localparam logic [4:0] ADDR_WRAP_L   = 5'h0A;
	localparam logic [4:0] ADDR_WRAP_H   = 5'h0B;
	localparam logic [4:0] ADDR_CMP_L    = 5'h0C;
	localparam logic [4:0] ADDR_CMP_H    = 5'h0D;
	localparam logic [4:0] ADDR_PIT_CTRL = 5'h10;
	localparam logic [4:0] ADDR_PIT_STAT = 5'h11;
	localparam logic [4:0] ADDR_PIT_IE   = 5'h12;
	localparam logic [4:0] ADDR_PIT_FLAG = 5'h13;
	localparam logic [4:0] ADDR_PIT_DBG  = 5'h15;

	localparam int ENABLE_BIT  = 0;
	localparam int FIELD_LSB   = 3;
	localparam int FIELD_MSB   = 6;
	localparam int WRAP_BIT    = 0;
	localparam int MATCH_BIT   = 1;
	localparam int KEEPRUN_BIT = 0;
	localparam logic [7:0] CTRL_MASK = 8'hF9;
	localparam logic [7:0] PIT_MASK  = 8'h79;

	localparam logic [7:0]  BYTE_RST = 8'h00;
	localparam logic [15:0] CNT_RST  = 16'h0000;
	localparam logic [15:0] WRAP_RST = 16'hFFFF;
	localparam logic [15:0] CMP_RST  = 16'h0000;

	localparam logic [3:0] PIT_OFF      = 4'h0;
	localparam logic [3:0] PIT_RESERVED = 4'hF;

	localparam int SYNC_CTRL = 0;
	localparam int SYNC_CNT  = 1;
	localparam int SYNC_WRAP = 2;
	localparam int SYNC_CMP  = 3;
	localparam int SYNC_PIT  = 4;
	localparam int SYNC_N    = 5;
	localparam logic [1:0] SYNC_TICKS = 2'h2;

	typedef enum logic [1:0] {
		internal_32khz_src = 2'h0,
		internal_1khz_src  = 2'h1,
		crystal_32khz_src  = 2'h2,
		pin_clock_src      = 2'h3
	} rtcpt_clock_source_t;
endpackage
`default_nettype wire

/* File: verification/rtcpt_top_tb.sv */
/*
 Self-checking testbench for the real-time counter and periodic tick timer.
 Assumes the byte register port of rtcpt_top and makes every counter clock edge by hand.
*/
`timescale 1ns/10ps
`default_nettype none
module rtcpt_top_tb;
	logic       ref_clk;
	logic       nrst;
	logic [3:0] src;
	logic       halt;
	logic [4:0] addr;
	logic [7:0] wdata;
	logic       wr_en;
	logic       rd_en;
	logic [7:0] rd_data;
	logic       rtc_irq;
	logic       pit_irq;
	int         fails;
	int         check_count;
	int         sel;
	logic [7:0] d;
	logic [7:0] b;

	rtcpt_top i_rtcpt_top (
		.ref_clk_i     (ref_clk),
		.nrst_i        (nrst),
		.internal_32khz_src_clk_i  (src[0]),
		.internal_1khz_src_clk_i   (src[1]),
		.xtal32k_clk_i (src[2]),
		.pin_clk_i     (src[3]),
		.debug_halt_i  (halt),
		.addr_i        (addr),
		.wr_data_i     (wdata),
		.wr_en_i       (wr_en),
		.rd_en_i       (rd_en),
		.rd_data_o     (rd_data),
		.rtc_irq_o     (rtc_irq),
		.pit_irq_o     (pit_irq)
	);

	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	task automatic test_done();
		if (fails == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		addr  <= a;
		wdata <= v;
		wr_en <= 1'b1;
		@(posedge ref_clk);
		wr_en <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so they are taken just past that edge.
	task automatic rd(input logic [4:0] a, output logic [7:0] v);
		@(posedge ref_clk);
		addr  <= a;
		rd_en <= 1'b1;
		@(posedge ref_clk);
		rd_en <= 1'b0;
		#1 v = rd_data;
	endtask

	task automatic wr16(input logic [4:0] a, input logic [15:0] v);
		wr(a, v[7:0]);
		wr(a + 5'h01, v[15:8]);
	endtask

	// Each source pulse is held long enough for the two-flop synchroniser and the edge detector.
	task automatic tick(input int n);
		repeat (n) begin
			@(posedge ref_clk);
			src[sel] <= 1'b1;
			repeat (5) @(posedge ref_clk);
			src[sel] <= 1'b0;
			repeat (5) @(posedge ref_clk);
		end
	endtask

	task automatic sync_wait(input logic [4:0] a, input logic [7:0] m);
		logic [7:0] s;
		for (int i = 0; i < 8; i++) begin
			rd(a, s);
			if ((s & m) == 8'h00) return;
			tick(1);
		end
		fails++;
		test_done();
	endtask

	task automatic t_reset();
		logic [4:0] a [14];
		logic [7:0] e [14];
		a = '{rtcpt_pkg::ADDR_DBG, rtcpt_pkg::ADDR_CLKSRC, rtcpt_pkg::ADDR_CNT_L,
			rtcpt_pkg::ADDR_CNT_H, rtcpt_pkg::ADDR_WRAP_L, rtcpt_pkg::ADDR_WRAP_H,
			rtcpt_pkg::ADDR_CMP_L, rtcpt_pkg::ADDR_CMP_H, rtcpt_pkg::ADDR_PIT_CTRL,
			rtcpt_pkg::ADDR_PIT_STAT, rtcpt_pkg::ADDR_PIT_IE, rtcpt_pkg::ADDR_PIT_FLAG,
			rtcpt_pkg::ADDR_PIT_DBG, 5'h06};
		e = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00,
			8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		for (int i = 0; i < 14; i++) begin
			rd(a[i], d);
			chk("reset value", d, e[i]);
		end
		chk("rtc_irq_o", {7'h00, rtc_irq}, 8'h00);
		chk("pit_irq_o", {7'h00, pit_irq}, 8'h00);
	endtask

	task automatic t_rw();
		wr(rtcpt_pkg::ADDR_DBG, 8'hFF);
		rd(rtcpt_pkg::ADDR_DBG, d);
		chk("keep_running_on_halt", d, 8'h01);
		wr(rtcpt_pkg::ADDR_DBG, 8'h00);
		wr(rtcpt_pkg::ADDR_CLKSRC, 8'hFF);
		rd(rtcpt_pkg::ADDR_CLKSRC, d);
		chk("clock_source_select", d, 8'h03);
		wr(rtcpt_pkg::ADDR_CLKSRC, 8'h00);
		wr16(rtcpt_pkg::ADDR_WRAP_L, 16'hA55A);
		wr16(rtcpt_pkg::ADDR_CMP_L, 16'h5AA5);
		rd(rtcpt_pkg::ADDR_WRAP_L, d);
		chk("wrap_limit low", d, 8'h5A);
		rd(rtcpt_pkg::ADDR_WRAP_H, d);
		chk("wrap_limit high", d, 8'hA5);
		rd(rtcpt_pkg::ADDR_CMP_L, d);
		chk("compare_value low", d, 8'hA5);
		rd(rtcpt_pkg::ADDR_CMP_H, d);
		chk("compare_value high", d, 8'h5A);
		wr(5'h06, 8'hFF);
		rd(5'h06, d);
		chk("unmapped", d, 8'h00);
	endtask

	// Every source is selected in turn; edges of the next source in order must not move the crossing.
	task automatic t_sources();
		logic [15:0] prev;
		prev = 16'h0000;
		for (int s = 0; s < 4; s++) begin
			wr(rtcpt_pkg::ADDR_CLKSRC, 8'(s));
			wr16(rtcpt_pkg::ADDR_CNT_L, 16'h1230 + 16'(s));
			rd(rtcpt_pkg::ADDR_STATUS, d);
			chk("counter_sync_pending", d & 8'h02, 8'h02);
			sel = (s + 1) % 4;
			tick(2);
			sel = s;
			tick(1);
			rd(rtcpt_pkg::ADDR_STATUS, d);
			chk("counter_sync_pending", d & 8'h02, 8'h02);
			rd(rtcpt_pkg::ADDR_CNT_L, d);
			chk("counter_value early", d, prev[7:0]);
			tick(1);
			rd(rtcpt_pkg::ADDR_STATUS, d);
			chk("counter_sync_pending", d & 8'h02, 8'h00);
			prev = 16'h1230 + 16'(s);
			rd(rtcpt_pkg::ADDR_CNT_L, d);
			chk("counter_value low", d, prev[7:0]);
			rd(rtcpt_pkg::ADDR_CNT_H, d);
			chk("counter_value high", d, prev[15:8]);
		end
	endtask

	task automatic t_count();
		sel = 0;
		wr(rtcpt_pkg::ADDR_CLKSRC, 8'h00);
		wr16(rtcpt_pkg::ADDR_CNT_L, 16'h0000);
		wr16(rtcpt_pkg::ADDR_WRAP_L, 16'h0003);
		wr16(rtcpt_pkg::ADDR_CMP_L, 16'h0002);
		sync_wait(rtcpt_pkg::ADDR_STATUS, 8'h0E);
		wr(rtcpt_pkg::ADDR_INT_FLAG, 8'h03);
		wr(rtcpt_pkg::ADDR_CTRL, 8'h01);
		sync_wait(rtcpt_pkg::ADDR_STATUS, 8'h01);
		rd(rtcpt_pkg::ADDR_CNT_L, b);
		chk("counter_value enabled", b, 8'h00);
		tick(3);
		rd(rtcpt_pkg::ADDR_CNT_L, d);
		chk("counter_value at limit", d, 8'h03);
		rd(rtcpt_pkg::ADDR_INT_FLAG, d);
		chk("match flag", d, 8'h02);
		chk("rtc_irq_o masked", {7'h00, rtc_irq}, 8'h00);
		tick(1);
		rd(rtcpt_pkg::ADDR_CNT_L, d);
		chk("counter_value wrapped", d, 8'h00);
		rd(rtcpt_pkg::ADDR_INT_FLAG, d);
		chk("wrap flag", d, 8'h03);
		wr(rtcpt_pkg::ADDR_INT_EN, 8'h01);
		repeat (3) @(posedge ref_clk);
		chk("rtc_irq_o wrap", {7'h00, rtc_irq}, 8'h01);
		wr(rtcpt_pkg::ADDR_INT_FLAG, 8'h01);
		rd(rtcpt_pkg::ADDR_INT_FLAG, d);
		chk("wrap flag cleared", d, 8'h02);
		chk("rtc_irq_o cleared", {7'h00, rtc_irq}, 8'h00);
		wr(rtcpt_pkg::ADDR_INT_EN, 8'h02);
		repeat (3) @(posedge ref_clk);
		chk("rtc_irq_o match", {7'h00, rtc_irq}, 8'h01);
		wr(rtcpt_pkg::ADDR_INT_EN, 8'h00);
		wr(rtcpt_pkg::ADDR_CTRL, 8'h11);
		sync_wait(rtcpt_pkg::ADDR_STATUS, 8'h01);
		rd(rtcpt_pkg::ADDR_CNT_L, b);
		tick(4);
		rd(rtcpt_pkg::ADDR_CNT_L, d);
		chk("counter_value divided", d, (b + 8'h01) & 8'h03);
		wr(rtcpt_pkg::ADDR_CTRL, 8'h01);
		sync_wait(rtcpt_pkg::ADDR_STATUS, 8'h01);
	endtask

	task automatic t_halt();
		@(posedge ref_clk);
		halt <= 1'b1;
		rd(rtcpt_pkg::ADDR_CNT_L, b);
		tick(3);
		rd(rtcpt_pkg::ADDR_CNT_L, d);
		chk("counter_value halted", d, b);
		wr(rtcpt_pkg::ADDR_DBG, 8'h01);
		tick(3);
		rd(rtcpt_pkg::ADDR_CNT_L, d);
		chk("counter_value running", d, (b + 8'h03) & 8'h03);
		wr(rtcpt_pkg::ADDR_DBG, 8'h00);
		halt <= 1'b0;
	endtask

	// Disabling first clears the tick count, so the first issue lands at a known edge.
	task automatic pit_arm(input logic [7:0] c);
		wr(rtcpt_pkg::ADDR_PIT_CTRL, 8'h00);
		sync_wait(rtcpt_pkg::ADDR_PIT_STAT, 8'h01);
		wr(rtcpt_pkg::ADDR_PIT_FLAG, 8'h01);
		wr(rtcpt_pkg::ADDR_PIT_CTRL, c);
		rd(rtcpt_pkg::ADDR_PIT_STAT, d);
		chk("tick_setup_sync_pending", d, 8'h01);
		sync_wait(rtcpt_pkg::ADDR_PIT_STAT, 8'h01);
	endtask

	task automatic pit_none(input logic [7:0] c, input logic h);
		@(posedge ref_clk);
		halt <= h;
		pit_arm(c);
		tick(8);
		rd(rtcpt_pkg::ADDR_PIT_FLAG, d);
		chk("tick flag silent", d, 8'h00);
		@(posedge ref_clk);
		halt <= 1'b0;
	endtask

	task automatic pit_period(input logic [3:0] iv);
		int n;
		n = 1 << (int'(iv) + 1);
		wr(rtcpt_pkg::ADDR_PIT_IE, 8'h01);
		pit_arm({1'b0, iv, 3'b001});
		tick(n - 2);
		rd(rtcpt_pkg::ADDR_PIT_FLAG, d);
		chk("tick flag early", d, 8'h00);
		chk("pit_irq_o early", {7'h00, pit_irq}, 8'h00);
		tick(2);
		rd(rtcpt_pkg::ADDR_PIT_FLAG, d);
		chk("tick flag", d, 8'h01);
		repeat (3) @(posedge ref_clk);
		chk("pit_irq_o", {7'h00, pit_irq}, 8'h01);
	endtask

	task automatic t_pit();
		for (int iv = 1; iv < 4; iv++) begin
			pit_period(4'(iv));
		end
		wr(rtcpt_pkg::ADDR_PIT_FLAG, 8'h00);
		rd(rtcpt_pkg::ADDR_PIT_FLAG, d);
		chk("tick flag kept", d, 8'h01);
		wr(rtcpt_pkg::ADDR_PIT_IE, 8'h00);
		repeat (3) @(posedge ref_clk);
		chk("pit_irq_o gated", {7'h00, pit_irq}, 8'h00);
		wr(rtcpt_pkg::ADDR_PIT_FLAG, 8'h01);
		rd(rtcpt_pkg::ADDR_PIT_FLAG, d);
		chk("tick flag cleared", d, 8'h00);
		pit_none(8'h01, 1'b0);
		pit_none(8'h79, 1'b0);
		pit_none(8'h08, 1'b0);
		pit_none(8'h09, 1'b1);
		wr(rtcpt_pkg::ADDR_PIT_DBG, 8'h01);
		@(posedge ref_clk);
		halt <= 1'b1;
		pit_period(4'h1);
		halt <= 1'b0;
	endtask

	initial begin
		nrst        = 1'b0;
		src         = 4'h0;
		halt        = 1'b0;
		addr        = 5'h00;
		wdata       = 8'h00;
		wr_en       = 1'b0;
		rd_en       = 1'b0;
		fails       = 0;
		check_count = 0;
		sel         = 0;
		repeat (6) @(posedge ref_clk);
		nrst <= 1'b1;
		repeat (3) @(posedge ref_clk);
		t_reset();
		t_rw();
		t_sources();
		t_count();
		t_halt();
		t_pit();
		test_done();
	end
endmodule
`default_nettype wire
